/* core/rom_pkg.sv */
// constants for the relay output matrix and fault recorder
package rom_pkg;

	// stage indices into the start and trip vectors
	localparam int unsigned STAGE_COUNT    = 4;
	localparam int unsigned ST_LOW_PHASE   = 0;
	localparam int unsigned ST_HIGH_PHASE  = 1;
	localparam int unsigned ST_LOW_EARTH   = 2;
	localparam int unsigned ST_HIGH_EARTH  = 3;

	// widths of recorded quantities
	localparam int unsigned STACK_DEPTH    = 5;
	localparam int unsigned PHASE_W        = 10;
	localparam int unsigned NEUTRAL_W      = 8;
	localparam int unsigned DUR_W          = 7;
	localparam int unsigned CNT_W          = 8;
	localparam int unsigned DEM_ACC_W      = 20;
	localparam int unsigned SMP_CNT_W      = 26;
	localparam int unsigned SMP_NUM_W      = 10;

	// routing group reset values
	localparam logic [7:0] TRIP_ROUTE_RST  = 8'ha5;
	localparam logic [7:0] AUX_ROUTE_RST   = 8'h00;
	localparam logic       ROUTE_SEL_TRIP  = 1'b0;
	localparam logic       ROUTE_SEL_AUX   = 1'b1;

	// phase current in tenths of rated current, neutral in percent
	localparam logic [PHASE_W-1:0]   PHASE_MAX   = 10'h276;
	localparam logic [NEUTRAL_W-1:0] NEUTRAL_MAX = 8'hd2;
	localparam logic [DUR_W-1:0]     DUR_SAT     = 7'h63;
	localparam logic [DUR_W-1:0]     DUR_TRIPPED = 7'h64;

	// display addressing
	localparam logic [3:0] DISP_BLANK      = 4'hf;
	localparam logic [3:0] REG_PHASE_A     = 4'h1;
	localparam logic [3:0] REG_PHASE_B     = 4'h2;
	localparam logic [3:0] REG_PHASE_C     = 4'h3;
	localparam logic [3:0] REG_DEMAND      = 4'h4;
	localparam logic [3:0] REG_DUR_LOW_PH  = 4'h5;
	localparam logic [3:0] REG_DUR_HIGH_PH = 4'h6;
	localparam logic [3:0] REG_NEUTRAL     = 4'h7;
	localparam logic [3:0] REG_DUR_LOW_E   = 4'h8;
	localparam logic [3:0] REG_DUR_HIGH_E  = 4'h9;

	typedef enum logic {
		ROM_DISP_MEAS = 1'b0,
		ROM_DISP_REC  = 1'b1
	} rom_disp_mode_t;

	// timing of the maximum-demand window
	localparam int unsigned CLK_PERIOD_NS    = 25;
	localparam int unsigned SAMPLE_PERIOD_MS = 1000;
	localparam int unsigned DEMAND_MIN       = 15;
	localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned DEMAND_SAMPLES   = DEMAND_MIN * 60 * 1000 / SAMPLE_PERIOD_MS;

endpackage : rom_pkg

/* core/rom_core.sv */
// relay output matrix, measurement display and fault recorder
//
// Function
// [R1] trip group bits 1,4 route phase trips to second start; bits 2,8 to third
// [R2] trip group bits 16,64 route earth trips to second start; 32,128 to third
// [R3] trip group resets to 165: switches one, three, six and eight set
// [R4] aux group bits 1,2 low phase start/trip, 4,8 high phase to aux trip
// [R5] aux group bits 16,32 low earth start/trip, 64,128 high earth to aux trip
// [R6] aux group resets to all switches cleared, checksum zero
// [R7] measurement mode shows value on right three digits, led names quantity
// [R8] phase currents shown as multiple of rated current, clamped to maximum
// [R9] neutral current shown as percent of rated current, clamped to maximum
// [R10] record mode: left digit is register number, right digits its contents
// [R11] phase stage start or trip captures all three phase currents
// [R12] each stack holds five entries; new capture shifts, sixth drops oldest
// [R13] 15-minute maximum demand of highest phase, plus highest since reset
// [R14] start clears duration counter, pushes old value; reads 100 once tripped
// [R15] each stage counts its starts from 0 to 255
// [R16] earth stage start or trip captures neutral current into its stack
// [R17] reset and program buttons together, or power loss, clear registers 1..9
// [R18] group checksum equals sum of set switch weights, i.e. its value
`timescale 1ns/1ps

module rom_core #(
	parameter int unsigned SAMPLE_CYCLES = rom_pkg::SAMPLE_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	input  wire logic [3:0]                    stage_start,
	input  wire logic [3:0]                    stage_trip,
	input  wire logic [3:0]                    pct_tick,
	input  wire logic [rom_pkg::PHASE_W-1:0]   phase_a_current,
	input  wire logic [rom_pkg::PHASE_W-1:0]   phase_b_current,
	input  wire logic [rom_pkg::PHASE_W-1:0]   phase_c_current,
	input  wire logic [rom_pkg::NEUTRAL_W-1:0] neutral_current,
	input  wire logic                          route_wr_en,
	input  wire logic                          route_wr_sel,
	input  wire logic [7:0]                    route_wr_data,
	input  wire logic                          reset_btn,
	input  wire logic                          program_btn,
	input  wire logic                          disp_mode,
	input  wire logic [3:0]                    disp_sel,
	input  wire logic [2:0]                    disp_idx,
	input  wire logic                          disp_sub,
	output logic                               second_start_output,
	output logic                               third_start_output,
	output logic                               aux_trip_output,
	output logic [7:0]                         trip_route_group,
	output logic [7:0]                         aux_trip_route_group,
	output logic [3:0]                         disp_addr,
	output logic [rom_pkg::PHASE_W-1:0]        disp_value,
	output logic [3:0]                         disp_led
);

	typedef struct packed {
		logic [7:0]                                  trip_route;
		logic [7:0]                                  aux_route;
		logic [3:0]                                  start_q;
		logic [3:0]                                  trip_q;
		logic [2:0][4:0][rom_pkg::PHASE_W-1:0]       cur_stk;
		logic [4:0][rom_pkg::NEUTRAL_W-1:0]          neu_stk;
		logic [3:0][4:0][rom_pkg::DUR_W-1:0]         dur_stk;
		logic [3:0][rom_pkg::CNT_W-1:0]              start_cnt;
		logic [rom_pkg::SMP_CNT_W-1:0]               smp_cnt;
		logic [rom_pkg::SMP_NUM_W-1:0]               smp_num;
		logic [rom_pkg::DEM_ACC_W-1:0]               dem_acc;
		logic [rom_pkg::PHASE_W-1:0]                 demand;
		logic [rom_pkg::PHASE_W-1:0]                 demand_max;
		logic                                        second_start;
		logic                                        third_start;
		logic                                        aux_trip;
		logic [3:0]                                  disp_addr;
		logic [rom_pkg::PHASE_W-1:0]                 disp_value;
		logic [3:0]                                  disp_led;
	} rom_state_t;

	rom_state_t                                 s;
	rom_state_t                                 next_s;
	logic [2:0][rom_pkg::PHASE_W-1:0]           ph;
	logic [rom_pkg::NEUTRAL_W-1:0]              neu;
	logic [rom_pkg::PHASE_W-1:0]                ph_max;
	logic [3:0]                                 rise_st;
	logic [3:0]                                 rise_tr;
	logic [rom_pkg::DEM_ACC_W-1:0]              dem_tot;
	logic [rom_pkg::PHASE_W-1:0]                dem_new;
	logic [2:0]                                 idx;

	assign second_start_output  = s.second_start;
	assign third_start_output   = s.third_start;
	assign aux_trip_output      = s.aux_trip;
	assign trip_route_group     = s.trip_route;
	assign aux_trip_route_group = s.aux_route;
	assign disp_addr            = s.disp_addr;
	assign disp_value           = s.disp_value;
	assign disp_led             = s.disp_led;

	always_comb
	begin
		next_s  = s;
		rise_st = stage_start & ~s.start_q;
		rise_tr = stage_trip & ~s.trip_q;
		// inputs beyond the display range are clamped, not wrapped
		ph[0]   = (phase_a_current > rom_pkg::PHASE_MAX) ? rom_pkg::PHASE_MAX
			: phase_a_current; // [R8]
		ph[1]   = (phase_b_current > rom_pkg::PHASE_MAX) ? rom_pkg::PHASE_MAX
			: phase_b_current; // [R8]
		ph[2]   = (phase_c_current > rom_pkg::PHASE_MAX) ? rom_pkg::PHASE_MAX
			: phase_c_current; // [R8]
		neu     = (neutral_current > rom_pkg::NEUTRAL_MAX) ? rom_pkg::NEUTRAL_MAX
			: neutral_current; // [R9]
		ph_max  = ph[0];
		if (ph[1] > ph_max)
		begin
			ph_max = ph[1];
		end
		if (ph[2] > ph_max)
		begin
			ph_max = ph[2];
		end
		dem_tot = s.dem_acc + rom_pkg::DEM_ACC_W'(ph_max);
		dem_new = rom_pkg::PHASE_W'(dem_tot / rom_pkg::DEMAND_SAMPLES);
		idx     = (disp_idx < 3'(rom_pkg::STACK_DEPTH)) ? disp_idx : 3'h0;
		next_s.start_q = stage_start;
		next_s.trip_q  = stage_trip;

		// settings writes; the group value is its own checksum
		if (route_wr_en)
		begin
			if (route_wr_sel == rom_pkg::ROUTE_SEL_AUX)
			begin
				next_s.aux_route = route_wr_data; // [R18]
			end
			else
			begin
				next_s.trip_route = route_wr_data; // [R18]
			end
		end

		// output matrix uses the settings already in force
		next_s.second_start = |(stage_trip & {s.trip_route[6], s.trip_route[4],
			s.trip_route[2], s.trip_route[0]}); // [R1] [R2]
		next_s.third_start = |(stage_trip & {s.trip_route[7], s.trip_route[5],
			s.trip_route[3], s.trip_route[1]}); // [R1] [R2]
		next_s.aux_trip = |(s.aux_route & {stage_trip[3], stage_start[3],
			stage_trip[2], stage_start[2], stage_trip[1], stage_start[1],
			stage_trip[0], stage_start[0]}); // [R4] [R5]

		// current captures on the edges of start and trip
		if (|(rise_st[1:0] | rise_tr[1:0]))
		begin
			for (int p = 0; p < 3; p++)
			begin
				next_s.cur_stk[p] = {s.cur_stk[p][3:0], ph[p]}; // [R11] [R12]
			end
		end
		if (|(rise_st[3:2] | rise_tr[3:2]))
		begin
			next_s.neu_stk = {s.neu_stk[3:0], neu}; // [R16] [R12]
		end

		// duration counters live in entry zero of each stack
		for (int g = 0; g < 4; g++)
		begin
			if (rise_st[g])
			begin
				next_s.dur_stk[g]   = {s.dur_stk[g][3:0], {rom_pkg::DUR_W{1'b0}}}; // [R14]
				next_s.start_cnt[g] = s.start_cnt[g] + 8'h01; // [R15]
			end
			else if (stage_start[g] && pct_tick[g] && s.dur_stk[g][0] < rom_pkg::DUR_SAT)
			begin
				next_s.dur_stk[g][0] = s.dur_stk[g][0] + 7'h01; // [R14]
			end
			if (stage_trip[g])
			begin
				next_s.dur_stk[g][0] = rom_pkg::DUR_TRIPPED; // [R14]
			end
		end

		// demand: mean of sampled highest phase over the window
		if (s.smp_cnt == rom_pkg::SMP_CNT_W'(SAMPLE_CYCLES - 1))
		begin
			next_s.smp_cnt = '0;
			if (s.smp_num == rom_pkg::SMP_NUM_W'(rom_pkg::DEMAND_SAMPLES - 1))
			begin
				next_s.smp_num = '0;
				next_s.dem_acc = '0;
				next_s.demand  = dem_new; // [R13]
				if (dem_new > s.demand_max)
				begin
					next_s.demand_max = dem_new; // [R13]
				end
			end
			else
			begin
				next_s.smp_num = s.smp_num + 10'h001;
				next_s.dem_acc = dem_tot;
			end
		end
		else
		begin
			next_s.smp_cnt = s.smp_cnt + 26'h000_0001;
		end

		// display
		next_s.disp_led   = 4'h0;
		next_s.disp_value = '0;
		if (disp_mode == rom_pkg::ROM_DISP_MEAS)
		begin
			next_s.disp_addr = rom_pkg::DISP_BLANK; // [R7]
			case (disp_sel)
				4'h0: next_s.disp_value = ph[0]; // [R8]
				4'h1: next_s.disp_value = ph[1]; // [R8]
				4'h2: next_s.disp_value = ph[2]; // [R8]
				4'h3: next_s.disp_value = rom_pkg::PHASE_W'(neu); // [R9]
				default: next_s.disp_value = '0;
			endcase
			if (disp_sel < 4'h4)
			begin
				next_s.disp_led = 4'h1 << disp_sel[1:0]; // [R7]
			end
		end
		else
		begin
			next_s.disp_addr = disp_sel; // [R10]
			case (disp_sel)
				rom_pkg::REG_PHASE_A: next_s.disp_value = s.cur_stk[0][idx];
				rom_pkg::REG_PHASE_B: next_s.disp_value = s.cur_stk[1][idx];
				rom_pkg::REG_PHASE_C: next_s.disp_value = s.cur_stk[2][idx];
				rom_pkg::REG_DEMAND: next_s.disp_value = disp_sub ? s.demand_max
					: s.demand; // [R13]
				rom_pkg::REG_NEUTRAL: next_s.disp_value =
					rom_pkg::PHASE_W'(s.neu_stk[idx]);
				rom_pkg::REG_DUR_LOW_PH: next_s.disp_value = disp_sub
					? rom_pkg::PHASE_W'(s.start_cnt[0]) : rom_pkg::PHASE_W'(s.dur_stk[0][idx]);
				rom_pkg::REG_DUR_HIGH_PH: next_s.disp_value = disp_sub
					? rom_pkg::PHASE_W'(s.start_cnt[1]) : rom_pkg::PHASE_W'(s.dur_stk[1][idx]);
				rom_pkg::REG_DUR_LOW_E: next_s.disp_value = disp_sub
					? rom_pkg::PHASE_W'(s.start_cnt[2]) : rom_pkg::PHASE_W'(s.dur_stk[2][idx]);
				rom_pkg::REG_DUR_HIGH_E: next_s.disp_value = disp_sub
					? rom_pkg::PHASE_W'(s.start_cnt[3]) : rom_pkg::PHASE_W'(s.dur_stk[3][idx]);
				default: next_s.disp_value = '0;
			endcase
		end

		// combined buttons win over any capture in the same cycle
		if (reset_btn && program_btn)
		begin
			next_s.cur_stk    = '0; // [R17]
			next_s.neu_stk    = '0; // [R17]
			next_s.dur_stk    = '0; // [R17]
			next_s.start_cnt  = '0; // [R17]
			next_s.dem_acc    = '0; // [R17]
			next_s.smp_num    = '0; // [R17]
			next_s.demand     = '0; // [R17]
			next_s.demand_max = '0; // [R17]
		end
	end

	// power loss is modelled by resetn; routing settings reload factory values
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s            <= '0; // [R17]
			s.trip_route <= rom_pkg::TRIP_ROUTE_RST; // [R3]
			s.aux_route  <= rom_pkg::AUX_ROUTE_RST; // [R6]
			s.disp_addr  <= rom_pkg::DISP_BLANK;
		end
		else if (ce)
		begin
			s <= next_s;
		end
	end

	sequence seq_low_phase_event;
		ce && (rise_st[0] || rise_tr[0]) && !(reset_btn && program_btn);
	endsequence

	sequence seq_low_earth_start;
		ce && rise_st[2] && !stage_trip[2] && !(reset_btn && program_btn);
	endsequence

	a_ss2_low_trip: assert property (@(posedge clk) disable iff (!resetn) // [R1]
		ce && stage_trip[0] && s.trip_route[0] |=> second_start_output)
		else $error("low phase trip not routed to second start output");

	a_ss3_earth_trip: assert property (@(posedge clk) disable iff (!resetn) // [R2]
		ce && stage_trip[3] && s.trip_route[7] |=> third_start_output)
		else $error("high earth trip not routed to third start output");

	a_route_factory: assert property (@(posedge clk) disable iff (!resetn) // [R3]
		$rose(resetn) |-> trip_route_group == rom_pkg::TRIP_ROUTE_RST)
		else $error("trip routing group not at factory value");

	a_aux_factory: assert property (@(posedge clk) disable iff (!resetn) // [R6]
		$rose(resetn) |-> aux_trip_route_group == rom_pkg::AUX_ROUTE_RST)
		else $error("aux routing group not cleared at reset");

	a_aux_quiet: assert property (@(posedge clk) disable iff (!resetn) // [R4]
		ce && (s.aux_route == 8'h00) |=> !aux_trip_output)
		else $error("aux trip output set with empty routing");

	a_meas_blank: assert property (@(posedge clk) disable iff (!resetn) // [R7]
		ce && disp_mode == rom_pkg::ROM_DISP_MEAS |=>
		disp_addr == rom_pkg::DISP_BLANK && $onehot0(disp_led))
		else $error("measurement mode shows a register number");

	a_rec_address: assert property (@(posedge clk) disable iff (!resetn) // [R10]
		ce && disp_mode == rom_pkg::ROM_DISP_REC |=> disp_addr == $past(disp_sel))
		else $error("record mode shows wrong register number");

	a_phase_range: assert property (@(posedge clk) disable iff (!resetn) // [R8]
		ce && disp_mode == rom_pkg::ROM_DISP_MEAS && disp_sel < 4'h3 |=>
		disp_value <= rom_pkg::PHASE_MAX)
		else $error("phase current beyond display range");

	a_phase_capture: assert property (@(posedge clk) disable iff (!resetn) // [R11]
		seq_low_phase_event |=> s.cur_stk[0][0] == $past(ph[0])
		&& s.cur_stk[0][1] == $past(s.cur_stk[0][0]))
		else $error("phase current not pushed on stage event");

	a_dur_restart: assert property (@(posedge clk) disable iff (!resetn) // [R14]
		seq_low_earth_start |=> s.dur_stk[2][0] == 7'h00
		&& s.dur_stk[2][1] == $past(s.dur_stk[2][0]))
		else $error("duration counter not restarted on start");

	a_dur_tripped: assert property (@(posedge clk) disable iff (!resetn) // [R14]
		ce && stage_trip[1] && !(reset_btn && program_btn) |=>
		s.dur_stk[1][0] == rom_pkg::DUR_TRIPPED)
		else $error("duration reading not 100 after trip");

	a_start_count: assert property (@(posedge clk) disable iff (!resetn) // [R15]
		seq_low_earth_start |=> s.start_cnt[2] == $past(s.start_cnt[2]) + 8'h01)
		else $error("start counter did not advance");

	a_btn_clear: assert property (@(posedge clk) disable iff (!resetn) // [R17]
		ce && reset_btn && program_btn |=> s.cur_stk == '0 && s.start_cnt == '0
		&& s.demand_max == '0)
		else $error("records not cleared by button pair");

endmodule : rom_core

/* bench/rom_panel.sv */
// panel model: relay coils, front display latch and push-buttons
`timescale 1ns/1ps

module rom_panel (
	input  wire logic                        clk,
	input  wire logic                        press,
	input  wire logic                        second_start_output,
	input  wire logic                        third_start_output,
	input  wire logic                        aux_trip_output,
	input  wire logic [3:0]                  disp_addr,
	input  wire logic [rom_pkg::PHASE_W-1:0] disp_value,
	output logic                             reset_btn,
	output logic                             program_btn,
	output logic [2:0]                       coil,
	output logic [13:0]                      digits
);
	// both buttons follow one press, as an operator pushes them together
	assign reset_btn   = press;
	assign program_btn = press;
	// coils and digits only follow the outputs; a panel gives nothing back
	always_ff @(posedge clk)
	begin
		coil   <= {aux_trip_output, third_start_output, second_start_output};
		digits <= {disp_addr, disp_value};
	end
endmodule : rom_panel

/* bench/tb.sv */
// self-checking bench for the relay output matrix and fault recorder
`timescale 1ns/1ps

module tb;
	logic       clk = 1'b0;
	logic       resetn = 1'b0;
	logic       ce = 1'b1;
	logic [3:0] stage_start = 4'h0;
	logic [3:0] stage_trip = 4'h0;
	logic [3:0] pct_tick = 4'h0;
	logic [9:0] phase_a_current = 10'h0c8;
	logic [9:0] phase_b_current = 10'h000;
	logic [9:0] phase_c_current = 10'h000;
	logic [7:0] neutral_current = 8'h00;
	logic       route_wr_en = 1'b0;
	logic       route_wr_sel = 1'b0;
	logic [7:0] route_wr_data = 8'h00;
	logic       press = 1'b0;
	logic       reset_btn;
	logic       program_btn;
	logic       disp_mode = 1'b0;
	logic [3:0] disp_sel = 4'h0;
	logic [2:0] disp_idx = 3'h0;
	logic       disp_sub = 1'b0;
	logic       second_start_output;
	logic       third_start_output;
	logic       aux_trip_output;
	logic [7:0] trip_route_group;
	logic [7:0] aux_trip_route_group;
	logic [3:0] disp_addr;
	logic [9:0] disp_value;
	logic [3:0] disp_led;
	int         err_total = 0;
	int         checks = 0;

	always #12.5 clk = ~clk;

	// a short sample period keeps the demand window at 3600 cycles
	rom_core #(.SAMPLE_CYCLES(4)) u_rom_core (.clk, .resetn, .ce, .stage_start, .stage_trip,
		.pct_tick, .phase_a_current, .phase_b_current, .phase_c_current, .neutral_current,
		.route_wr_en, .route_wr_sel, .route_wr_data, .reset_btn, .program_btn, .disp_mode,
		.disp_sel, .disp_idx, .disp_sub, .second_start_output, .third_start_output,
		.aux_trip_output, .trip_route_group, .aux_trip_route_group, .disp_addr,
		.disp_value, .disp_led);

	rom_panel u_rom_panel (.clk, .press, .second_start_output, .third_start_output,
		.aux_trip_output, .disp_addr, .disp_value, .reset_btn, .program_btn,
		.coil(), .digits());

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic chk_val(input string nm, input logic [9:0] exp, input logic [9:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk_val

	task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
		chk_val(nm, {2'b00, exp}, {2'b00, got});
	endtask : chk_byte

	task automatic chk_bit(input string nm, input logic exp, input logic got);
		chk_val(nm, {9'h000, exp}, {9'h000, got});
	endtask : chk_bit

	task automatic wr(input logic sel, input logic [7:0] data);
		route_wr_en = 1'b1;
		route_wr_sel = sel;
		route_wr_data = data;
		step(1);
		route_wr_en = 1'b0;
	endtask : wr

	task automatic show(input logic m, input logic [3:0] s, input int i, input logic sub);
		disp_mode = m;
		disp_sel = s;
		disp_idx = 3'(i);
		disp_sub = sub;
		step(2);
	endtask : show

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// the whole run is about 4000 cycles
	initial
	begin
		#(25 * 20000);
		err_total++;
		conclude();
	end

	initial
	begin
		step(2);
		resetn = 1'b1;
		step(1);
		chk_byte("trip group", 8'ha5, trip_route_group);
		chk_byte("aux group", 8'h00, aux_trip_route_group);
		$display("test factory done");
		for (int n = 0; n < 8; n++)
		begin
			wr(1'b0, 8'h01 << n);
			chk_byte("trip group", 8'h01 << n, trip_route_group);
			stage_trip = 4'h1 << (n / 2);
			step(2);
			chk_bit("second start", n % 2 == 0, second_start_output);
			chk_bit("third start", n % 2 == 1, third_start_output);
			stage_trip = 4'h0;
			wr(1'b1, 8'h01 << n);
			chk_byte("aux group", 8'h01 << n, aux_trip_route_group);
			// the other kind of the same stage must not reach the output
			if (n % 2 == 1)
				stage_start = 4'h1 << (n / 2);
			else
				stage_trip = 4'h1 << (n / 2);
			step(2);
			chk_bit("aux trip idle", 1'b0, aux_trip_output);
			{stage_start, stage_trip} = {stage_trip, stage_start};
			step(2);
			chk_bit("aux trip", 1'b1, aux_trip_output);
			{stage_start, stage_trip} = 8'h00;
			step(2);
		end
		$display("test matrix done");
		show(1'b1, rom_pkg::REG_PHASE_A, 0, 1'b0);
		chk_val("reg1 newest", 10'h0c8, disp_value);
		press = 1'b1;
		step(1);
		press = 1'b0;
		show(1'b1, rom_pkg::REG_PHASE_A, 0, 1'b0);
		chk_val("reg1 cleared", 10'h000, disp_value);
		show(1'b1, rom_pkg::REG_DUR_LOW_PH, 0, 1'b1);
		chk_val("count cleared", 10'h000, disp_value);
		chk_byte("trip group kept", 8'h80, trip_route_group);
		$display("test clear done");
		for (int k = 1; k <= 6; k++)
		begin
			phase_a_current = 10'(10 * k);
			neutral_current = 8'(k);
			stage_start = 4'h5;
			step(1);
			pct_tick = 4'h5;
			step(k);
			pct_tick = 4'h0;
			step(1);
			stage_start = 4'h0;
			step(1);
		end
		for (int i = 0; i < 5; i++)
		begin
			show(1'b1, rom_pkg::REG_PHASE_A, i, 1'b0);
			chk_val("reg1 stack", 10'(10 * (6 - i)), disp_value);
			chk_val("reg number", 10'h001, {6'h00, disp_addr});
			show(1'b1, rom_pkg::REG_DUR_LOW_PH, i, 1'b0);
			chk_val("reg5 stack", 10'(6 - i), disp_value);
			show(1'b1, rom_pkg::REG_NEUTRAL, i, 1'b0);
			chk_val("reg7 stack", 10'(6 - i), disp_value);
			show(1'b1, rom_pkg::REG_DUR_LOW_E, i, 1'b0);
			chk_val("reg8 stack", 10'(6 - i), disp_value);
		end
		// a frozen clock enable must ignore the button pair and a new start
		ce = 1'b0;
		press = 1'b1;
		stage_start = 4'h1;
		step(2);
		press = 1'b0;
		stage_start = 4'h0;
		ce = 1'b1;
		show(1'b1, rom_pkg::REG_DUR_LOW_PH, 0, 1'b1);
		chk_val("reg5 count", 10'h006, disp_value);
		show(1'b1, rom_pkg::REG_DUR_LOW_E, 0, 1'b1);
		chk_val("reg8 count", 10'h006, disp_value);
		stage_start = 4'h8;
		stage_trip = 4'h8;
		step(2);
		{stage_start, stage_trip} = 8'h00;
		show(1'b1, rom_pkg::REG_DUR_HIGH_E, 0, 1'b0);
		chk_val("reg9 tripped", 10'h064, disp_value);
		show(1'b1, rom_pkg::REG_DUR_HIGH_E, 0, 1'b1);
		chk_val("reg9 count", 10'h001, disp_value);
		$display("test records done");
		phase_a_current = 10'h064;
		phase_b_current = 10'h2bc;
		phase_c_current = 10'h005;
		neutral_current = 8'hfa;
		for (int s = 0; s < 4; s++)
		begin
			show(1'b0, 4'(s), 0, 1'b0);
			chk_val("measured", s == 0 ? 10'h064 : s == 1 ? 10'h276 : s == 2 ? 10'h005
				: 10'h0d2, disp_value);
			chk_val("led", 10'h001 << s, {6'h00, disp_led});
		end
		$display("test measure done");
		phase_a_current = 10'h032;
		phase_b_current = 10'h0c8;
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		show(1'b1, rom_pkg::REG_NEUTRAL, 0, 1'b0);
		chk_val("reg7 power loss", 10'h000, disp_value);
		step(3700);
		show(1'b1, rom_pkg::REG_DEMAND, 0, 1'b0);
		chk_val("demand", 10'h0c8, disp_value);
		show(1'b1, rom_pkg::REG_DEMAND, 0, 1'b1);
		chk_val("demand max", 10'h0c8, disp_value);
		$display("test demand done");
		conclude();
	end
endmodule : tb
